// ==== hw/ssf_pkg.sv ====
// package for the serial status flag block: offsets, layouts, reset values
package ssf_pkg;

  // register bus address width and status register offset
  localparam int SSF_ADDR_W = 7;
  localparam logic [SSF_ADDR_W-1:0] SSF_STATUS_OFS = 7'h64;

  // read data width and the number of flag bits held here
  localparam int SSF_DATA_W = 32;
  localparam int SSF_FLAG_W = 7;

  // allowed fifo depths; zero means the fifo is left out
  localparam int SSF_DEPTH_NONE = 0;
  localparam int SSF_DEPTH_SMALL = 16;
  localparam int SSF_DEPTH_LARGE = 256;

  // lane configuration of the serial side
  typedef enum logic [1:0] {
    SSF_LANE_STD = 2'h0,
    SSF_LANE_DUAL = 2'h1,
    SSF_LANE_QUAD = 2'h2
  } ssf_lane_t;

  // layout of the low seven bits of serial_status, bit 6 first
  typedef struct packed {
    logic clock_shape_mismatch_flag;
    logic target_sel_n;
    logic mode_fault_flag;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
  } ssf_status_t;

  // reset value: target not selected, both sides empty
  localparam ssf_status_t SSF_STATUS_RST = 7'h25;

  // static configuration from the control logic
  typedef struct packed {
    logic mem_supported;
    logic cpol;
    logic cpha;
    logic controller;
  } ssf_cfg_t;

  // register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [SSF_ADDR_W-1:0] addr;
  } ssf_req_t;

  // data-path events from the bus side
  typedef struct packed {
    logic tx_wr;
    logic rx_rd;
  } ssf_evt_t;

endpackage : ssf_pkg

// ==== hw/ssf_status.sv ====
// serial status flag logic: low seven bits of serial_status
`timescale 1ns/1ps
`default_nettype none

module ssf_status
  import ssf_pkg::*;
#(
  parameter ssf_lane_t LANE_MODE = SSF_LANE_STD,
  parameter int TX_DEPTH = SSF_DEPTH_SMALL,
  parameter int RX_DEPTH = SSF_DEPTH_SMALL
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // link clock and the shifter's transfer-done pulse on it
  input wire logic i_link_clk,
  input wire logic i_link_xfer_done,
  // slave select pin, active low, asynchronous
  input wire logic i_ss_b,
  // configuration and data-path events
  input wire ssf_pkg::ssf_cfg_t i_cfg,
  input wire ssf_pkg::ssf_evt_t i_evt,
  // register port
  input wire ssf_pkg::ssf_req_t i_req,
  output logic [ssf_pkg::SSF_DATA_W-1:0] o_rdata,
  // flags and mode-fault strobe
  output ssf_pkg::ssf_status_t o_status,
  output logic o_mode_fault_flag_strobe
);
  import ssf_pkg::*;

  localparam int TX_CW = $clog2(TX_DEPTH + 2);
  localparam int RX_CW = $clog2(RX_DEPTH + 2);

  // parameters the logic cannot serve are refused at elaboration
  // fifos required in multi-lane
  if (LANE_MODE != SSF_LANE_STD && (TX_DEPTH == SSF_DEPTH_NONE || RX_DEPTH == SSF_DEPTH_NONE))
  begin : g_bad_lane
    $error("dual or quad lane mode needs both fifos");
  end
  if (TX_DEPTH != SSF_DEPTH_NONE && TX_DEPTH != SSF_DEPTH_SMALL && TX_DEPTH != SSF_DEPTH_LARGE)
  begin : g_bad_tx_depth
    $error("unsupported transmit fifo depth");
  end
  if (RX_DEPTH != SSF_DEPTH_NONE && RX_DEPTH != SSF_DEPTH_SMALL && RX_DEPTH != SSF_DEPTH_LARGE)
  begin : g_bad_rx_depth
    $error("unsupported receive fifo depth");
  end

  logic link_rst_meta_r;
  logic link_rst_b_r;
  logic link_tog_r;
  logic done_meta_r;
  logic done_sync_r;
  logic done_last_r;
  logic xfer_done;
  logic ss_meta_r;
  logic ss_sync_b_r;
  logic ss_last_b_r;
  logic status_rd;
  logic mode_fault_flag_set;
  logic mode_fault_flag_r;
  logic mode_fault_flag_nxt;
  logic mode_fault_flag_strobe_r;
  logic mismatch_r;
  logic target_sel_n_r;
  logic tx_full_r;
  logic tx_empty_r;
  logic rx_full_r;
  logic rx_empty_r;
  logic [SSF_DATA_W-1:0] rdata_r;

  // reset brought into the link domain; release is seen on link edges only
  always_ff @(posedge i_link_clk)
  begin
    link_rst_meta_r <= i_rst_b;
    link_rst_b_r <= link_rst_meta_r;
  end

  // transfer-done pulse becomes a toggle, which survives a stopped link clock
  always_ff @(posedge i_link_clk)
  begin
    if (!link_rst_b_r)
      link_tog_r <= 1'b0;
    else if (i_link_xfer_done)
      link_tog_r <= ~link_tog_r;
  end

  // toggle synchronised into the core domain, edge taken past the second flop
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
      done_last_r <= 1'b0;
    end
    else
    begin
      done_meta_r <= link_tog_r;
      done_sync_r <= done_meta_r;
      done_last_r <= done_sync_r;
    end
  end
  assign xfer_done = done_sync_r ^ done_last_r;

  // slave select pin through two flops; high while idle
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      ss_meta_r <= 1'b1;
      ss_sync_b_r <= 1'b1;
      ss_last_b_r <= 1'b1;
    end
    else
    begin
      ss_meta_r <= i_ss_b;
      ss_sync_b_r <= ss_meta_r;
      ss_last_b_r <= ss_sync_b_r;
    end
  end

  // register port decode; writes have no target here
  // a status read clears the mode fault flag
  assign status_rd = i_req.rd && (i_req.addr == SSF_STATUS_OFS);

  assign mode_fault_flag_set = i_cfg.controller && ss_last_b_r && !ss_sync_b_r;

  // set wins over the read clear so a fault landing on a read is kept
  // clear on status read
  always_comb
  begin
    mode_fault_flag_nxt = mode_fault_flag_r;
    if (status_rd)
      mode_fault_flag_nxt = 1'b0;
    if (mode_fault_flag_set)
      mode_fault_flag_nxt = 1'b1;
  end

  // mode fault flag
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      mode_fault_flag_r <= SSF_STATUS_RST.mode_fault_flag;
    else
      mode_fault_flag_r <= mode_fault_flag_nxt;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      mode_fault_flag_strobe_r <= 1'b0;
    else
      mode_fault_flag_strobe_r <= mode_fault_flag_nxt && !mode_fault_flag_r;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      mismatch_r <= SSF_STATUS_RST.clock_shape_mismatch_flag;
    else
      mismatch_r <= (LANE_MODE != SSF_LANE_STD) && i_cfg.mem_supported && (i_cfg.cpol ^ i_cfg.cpha);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      target_sel_n_r <= SSF_STATUS_RST.target_sel_n;
    else
      target_sel_n_r <= !(!i_cfg.controller && !ss_sync_b_r);
  end

  // transmit side flags
  generate
    if (TX_DEPTH == SSF_DEPTH_NONE)
    begin : g_tx_reg
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
          tx_full_r <= SSF_STATUS_RST.tx_full;
        else if (i_evt.tx_wr)
          tx_full_r <= 1'b1;
        else if (xfer_done)
          tx_full_r <= 1'b0;
      end
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
          tx_empty_r <= SSF_STATUS_RST.tx_empty;
        else if (i_evt.tx_wr)
          tx_empty_r <= 1'b0;
        else if (xfer_done)
          tx_empty_r <= 1'b1;
      end
    end
    else
    begin : g_tx_fifo
      logic [TX_CW-1:0] tx_cnt_r;
      logic [TX_CW-1:0] tx_cnt_nxt;
      // a write into a full fifo is refused upstream and not counted
      // drop on transfer done
      always_comb
      begin
        tx_cnt_nxt = tx_cnt_r;
        if (i_evt.tx_wr && tx_cnt_r != TX_CW'(TX_DEPTH))
          tx_cnt_nxt = tx_cnt_nxt + 1'b1;
        if (xfer_done && tx_cnt_r != '0)
          tx_cnt_nxt = tx_cnt_nxt - 1'b1;
      end
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
          tx_cnt_r <= '0;
        else
          tx_cnt_r <= tx_cnt_nxt;
      end
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
        begin
          tx_full_r <= SSF_STATUS_RST.tx_full;
          tx_empty_r <= SSF_STATUS_RST.tx_empty;
        end
        else
        begin
          tx_full_r <= (tx_cnt_nxt == TX_CW'(TX_DEPTH));
          tx_empty_r <= (tx_cnt_nxt == '0);
        end
      end
    end
  endgenerate

  // receive side flags
  generate
    if (RX_DEPTH == SSF_DEPTH_NONE)
    begin : g_rx_reg
      // new data wins over a read in the same cycle
      // full on transfer done
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
          rx_full_r <= SSF_STATUS_RST.rx_full;
        else if (xfer_done)
          rx_full_r <= 1'b1;
        else if (i_evt.rx_rd)
          rx_full_r <= 1'b0;
      end
      assign rx_empty_r = !rx_full_r;
    end
    else
    begin : g_rx_fifo
      logic [RX_CW-1:0] rx_cnt_r;
      logic [RX_CW-1:0] rx_cnt_nxt;
      // overrun drops data upstream, so the count saturates at depth
      // rise per transfer
      always_comb
      begin
        rx_cnt_nxt = rx_cnt_r;
        if (xfer_done && rx_cnt_r != RX_CW'(RX_DEPTH))
          rx_cnt_nxt = rx_cnt_nxt + 1'b1;
        if (i_evt.rx_rd && rx_cnt_r != '0)
          rx_cnt_nxt = rx_cnt_nxt - 1'b1;
      end
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
          rx_cnt_r <= '0;
        else
          rx_cnt_r <= rx_cnt_nxt;
      end
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_b)
        begin
          rx_full_r <= SSF_STATUS_RST.rx_full;
          rx_empty_r <= SSF_STATUS_RST.rx_empty;
        end
        else
        begin
          rx_full_r <= (rx_cnt_nxt == RX_CW'(RX_DEPTH));
          rx_empty_r <= (rx_cnt_nxt == '0);
        end
      end
    end
  endgenerate

  // flag vector as one struct
  assign o_status = '{
    clock_shape_mismatch_flag: mismatch_r,
    target_sel_n: target_sel_n_r,
    mode_fault_flag: mode_fault_flag_r,
    tx_full: tx_full_r,
    tx_empty: tx_empty_r,
    rx_full: rx_full_r,
    rx_empty: rx_empty_r
  };

  // read data one cycle after the read; unmapped offsets read as zero
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      rdata_r <= '0;
    else if (status_rd)
      rdata_r <= {{(SSF_DATA_W - SSF_FLAG_W){1'b0}}, o_status};
    else
      rdata_r <= '0;
  end

  assign o_rdata = rdata_r;
  assign o_mode_fault_flag_strobe = mode_fault_flag_strobe_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  mismatch_set_a: assert property (
    (LANE_MODE != SSF_LANE_STD) && i_cfg.mem_supported && (i_cfg.cpol != i_cfg.cpha)
    |=> mismatch_r)
    else $error("mismatch flag not set for bad clock shape");

  mismatch_quiet_a: assert property (
    (LANE_MODE == SSF_LANE_STD) || (i_cfg.cpol == i_cfg.cpha) |=> !mismatch_r)
    else $error("mismatch flag raised wrongly");

  target_sel_a: assert property (
    !i_cfg.controller && !ss_sync_b_r |=> !o_status.target_sel_n)
    else $error("target select flag not low while selected");

  mode_fault_flag_set_a: assert property (
    $fell(ss_sync_b_r) && i_cfg.controller |=> mode_fault_flag_r)
    else $error("mode fault not set on select");

  mode_fault_flag_clear_a: assert property (
    status_rd && !mode_fault_flag_set |=> !mode_fault_flag_r)
    else $error("mode fault not cleared by status read");

  mode_fault_flag_strobe_a: assert property (
    $rose(mode_fault_flag_r) |-> o_mode_fault_flag_strobe ##1 !o_mode_fault_flag_strobe)
    else $error("mode fault strobe not one cycle");

  strobe_cause_a: assert property (
    o_mode_fault_flag_strobe |-> $rose(mode_fault_flag_r))
    else $error("strobe without a mode fault rise");

  tx_write_a: assert property (
    i_evt.tx_wr |=> !o_status.tx_empty)
    else $error("transmit empty not cleared by write");

  tx_excl_a: assert property (
    !(o_status.tx_full && o_status.tx_empty))
    else $error("transmit full and empty together");

  rx_done_a: assert property (
    xfer_done |=> !o_status.rx_empty)
    else $error("receive still empty after transfer");

  rx_excl_a: assert property (
    !(o_status.rx_full && o_status.rx_empty) || RX_DEPTH == SSF_DEPTH_NONE)
    else $error("receive full and empty together");

  rdata_a: assert property (
    status_rd |=> o_rdata[SSF_FLAG_W-1:0] == $past(o_status, 1)
      && o_rdata[SSF_DATA_W-1:SSF_FLAG_W] == '0)
    else $error("status read data wrong");

endmodule : ssf_status

`default_nettype wire

// ==== tb/ssf_far_end.sv ====
// far-end model: serial controller clock and the shifter's transfer-done pulse
`timescale 1ns/1ps
`default_nettype none
module ssf_far_end (
  // reset, so the link clock also runs while the core resets
  input wire logic i_rst_b,
  // link clock and transfer-done pulse
  output logic o_link_clk,
  output logic o_link_xfer_done
);
  logic frame_r = 1'b0;
  // clock runs only in frames or reset; the 37 ns offset keeps it off the core grid
  initial
  begin
    o_link_clk = 1'b0;
    o_link_xfer_done = 1'b0;
    #37;
    forever
    begin
      #80;
      o_link_clk = (frame_r || !i_rst_b) ? ~o_link_clk : 1'b0;
    end
  end
  // one frame, done launched on a falling edge so the rising edge sees it cleanly
  task automatic xfer();
    frame_r = 1'b1;
    repeat (2) @(posedge o_link_clk);
    @(negedge o_link_clk);
    o_link_xfer_done = 1'b1;
    @(negedge o_link_clk);
    o_link_xfer_done = 1'b0;
    repeat (2) @(posedge o_link_clk);
    frame_r = 1'b0;
  endtask : xfer
endmodule : ssf_far_end
`default_nettype wire

// ==== tb/tb_ssf_status.sv ====
// bench for the status flags: a no-fifo standard build and a dual-lane fifo build
`timescale 1ns/1ps
`default_nettype none
module tb_ssf_status;
  import ssf_pkg::*;
  logic clk;
  logic rst_b;
  logic ss_b;
  ssf_cfg_t cfg;
  ssf_evt_t evt;
  ssf_req_t req;
  wire logic lclk;
  wire logic ldone;
  logic [SSF_DATA_W-1:0] rd1;
  logic [SSF_DATA_W-1:0] rd2;
  ssf_status_t st1;
  ssf_status_t st2;
  logic stb1;
  logic stb2;
  int n_errors = 0;
  int cmp_count = 0;
  int n_stb1 = 0;
  int n_stb2 = 0;
  logic [31:0] seed_r = 32'h0e95b968;
  logic [63:0] exp_r;
  logic [63:0] exp_q[$];

  // both builds share every input, so each stimulus drives two variants
  ssf_status #(.LANE_MODE(SSF_LANE_STD), .TX_DEPTH(SSF_DEPTH_NONE),
    .RX_DEPTH(SSF_DEPTH_NONE)) uut (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_link_clk(lclk), .i_link_xfer_done(ldone), .i_ss_b(ss_b), .i_cfg(cfg),
    .i_evt(evt), .i_req(req), .o_rdata(rd1), .o_status(st1), .o_mode_fault_flag_strobe(stb1));
  ssf_status #(.LANE_MODE(SSF_LANE_DUAL), .TX_DEPTH(SSF_DEPTH_SMALL),
    .RX_DEPTH(SSF_DEPTH_SMALL)) uut_fifo (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_link_clk(lclk), .i_link_xfer_done(ldone), .i_ss_b(ss_b), .i_cfg(cfg),
    .i_evt(evt), .i_req(req), .o_rdata(rd2), .o_status(st2), .o_mode_fault_flag_strobe(stb2));
  ssf_far_end far (.i_rst_b(rst_b), .o_link_clk(lclk), .o_link_xfer_done(ldone));

  // core clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // every driver starts and ends 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input ssf_status_t a, input ssf_status_t e);
    cmp_count++;
    if (a !== e)
    begin
      n_errors++;
      $display("BAD %0t status %h exp %h", $time, a, e);
    end
  endtask : chk

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e)
    begin
      n_errors++;
      $display("BAD %0t rdata %h exp %h", $time, a, e);
    end
  endtask : chk_rd

  task automatic chk_n(input int a, input int e);
    cmp_count++;
    if (a != e)
    begin
      n_errors++;
      $display("BAD %0t strobe count %0d exp %0d", $time, a, e);
    end
  endtask : chk_n

  // register access; a read notes both expected words first
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] e1,
    input logic [31:0] e2);
    if (!w)
      exp_q.push_back({e2, e1});
    req = '{rd: !w, wr: w, addr: a};
    cyc(1);
    req = '0;
    cyc(1);
  endtask : bus

  task automatic ev(input ssf_evt_t e);
    evt = e;
    cyc(1);
    evt = '0;
    cyc(1);
  endtask : ev

  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // read data shows one cycle after the read is taken
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (req.rd === 1'b1)
      begin
        // the word stands only until the next edge, so look just after this one
        #1;
        exp_r = exp_q.pop_front();
        chk_rd(rd1, exp_r[31:0]);
        chk_rd(rd2, exp_r[63:32]);
      end
    end
  end

  // count strobe cycles; one rise must give exactly one
  always @(posedge clk)
  begin
    if (stb1 === 1'b1)
      n_stb1++;
    if (stb2 === 1'b1)
      n_stb2++;
  end

  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    rst_b = 1'b0;
    ss_b = 1'b1;
    cfg = 4'h9;
    evt = '0;
    req = '0;
    // held over 8 link periods so the link-side flops are reset too
    repeat (8) @(posedge lclk);
    cyc(1);
    rst_b = 1'b1;
    cyc(1);
    chk(st1, SSF_STATUS_RST);
    chk(st2, SSF_STATUS_RST);
    bus(1'b0, SSF_STATUS_OFS, 32'h25, 32'h25);
    // four polarity/phase pairs, then unsupported memory with 00 and 01
    for (int i = 0; i < 6; i++)
    begin
      cfg = {(i < 4), i[1], i[0], 1'b1};
      cyc(3);
      chk(st2, {(i < 4) && (i[1] ^ i[0]), 6'h25});
      chk(st1, SSF_STATUS_RST);
    end
    cfg = 4'h9;
    seed_r = xs(seed_r);
    cyc(3 + seed_r[2:0]);
    ss_b = 1'b0;
    cyc(6);
    chk(st1, 7'h35);
    chk(st2, 7'h35);
    chk_n(n_stb1, 1);
    chk_n(n_stb2, 1);
    bus(1'b1, SSF_STATUS_OFS, 32'h0, 32'h0);
    chk(st1, 7'h35);
    bus(1'b0, SSF_STATUS_OFS, 32'h35, 32'h35);
    bus(1'b0, SSF_STATUS_OFS, 32'h25, 32'h25);
    chk(st2, SSF_STATUS_RST);
    chk_n(n_stb1, 1);
    seed_r = xs(seed_r);
    bus(1'b0, (seed_r[6:0] == SSF_STATUS_OFS) ? 7'h00 : seed_r[6:0], 32'h0, 32'h0);
    ss_b = 1'b1;
    cyc(4);
    cfg = 4'h8;
    ss_b = 1'b0;
    cyc(6);
    chk(st1, 7'h05);
    chk(st2, 7'h05);
    ss_b = 1'b1;
    cfg = 4'h9;
    cyc(6);
    chk(st1, SSF_STATUS_RST);
    // single word through both builds
    ev(2'b10);
    chk(st1, 7'h29);
    chk(st2, 7'h21);
    far.xfer();
    cyc(8);
    chk(st1, 7'h26);
    chk(st2, 7'h24);
    ev(2'b01);
    chk(st1, SSF_STATUS_RST);
    chk(st2, SSF_STATUS_RST);
    // fill the transmit fifo to the brim, watching the last slot
    for (int k = 1; k <= 16; k++)
    begin
      ev(2'b10);
      chk(st2, (k == 16) ? 7'h29 : 7'h21);
    end
    chk(st1, 7'h29);
    // each completed transfer moves one word from transmit to receive
    for (int k = 1; k <= 16; k++)
    begin
      far.xfer();
      seed_r = xs(seed_r);
      cyc(4 + seed_r[3:0]);
      chk(st2, {3'h2, 1'b0, k == 16, k == 16, 1'b0});
    end
    chk(st2, 7'h26);
    chk(st1, 7'h26);
    for (int k = 1; k <= 16; k++)
    begin
      ev(2'b01);
      chk(st2, {5'h09, 1'b0, k == 16});
    end
    chk(st1, SSF_STATUS_RST);
    cyc(2);
    report_and_stop();
  end
endmodule : tb_ssf_status
`default_nettype wire
